// ===== include/mtw_pkg.sv
// ==========================================================
// Register map
// ==========================================================
package mtw_pkg;
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_TXD = 8'h04;
	localparam logic [7:0] ADDR_RXD = 8'h08;
	localparam logic [7:0] ADDR_CRC = 8'h0C;
	localparam logic [7:0] ADDR_BAUD = 8'h10;
	localparam logic [7:0] ADDR_CTRL = 8'h14;
	localparam logic [7:0] ADDR_OWN = 8'h18;
	// ======================================================
	// Field positions
	// ======================================================
	localparam int ST_NACK = 0;
	localparam int ST_SDIR = 1;
	localparam int ST_CRCRDY = 2;
	localparam int ST_TXE = 3;
	localparam int ST_RXF = 4;
	localparam int ST_HIT = 5;
	localparam int ST_TXDONE = 6;
	localparam int ST_RXNEW = 7;
	localparam int CT_ON = 0;
	localparam int CT_MST = 1;
	localparam int CT_DIR = 2;
	localparam int CT_NOACK = 3;
	localparam int CT_BUSY = 4;
	localparam int CT_LOST = 5;
	// ======================================================
	// Reset values and constants
	// ======================================================
	localparam logic [7:0] STATUS_RST = 8'h09;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'h00;
	localparam logic [9:0] QTR_BASE = 10'h005;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_PRE = 4'hF;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [5:0] {
		M_IDLE = 6'h01,
		M_START = 6'h02,
		M_LOW = 6'h04,
		M_HIGH = 6'h08,
		M_STOP = 6'h10,
		M_END = 6'h20
	} mtw_mst_t;
endpackage

// ===== rtl/mtw_baud.sv
`timescale 1ns/10ps
// ==========================================================
// Quarter-bit tick divider
// ==========================================================
module mtw_baud
	import mtw_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic en,
	input wire logic [2:0] sel,
	output logic tick
);
	logic [9:0] cnt_q;
	logic [9:0] top;

	// A bit takes four ticks, so each tick is a quarter of 20 << sel.
	assign top = 10'((QTR_BASE << sel) - 10'h001); // [R14]
	assign tick = en & (cnt_q >= top);

	// Counter restarts while disabled so the first bit is full length.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || !en)
			cnt_q <= 10'h000;
		else if (cnt_q >= top)
			cnt_q <= 10'h000;
		else
			cnt_q <= cnt_q + 10'h001;
	end
endmodule // mtw_baud

// ===== rtl/mtw_crc8.sv
`timescale 1ns/10ps
// ==========================================================
// One-byte CRC step
// ==========================================================
module mtw_crc8
	import mtw_pkg::*;
(
	input wire logic [7:0] crc_in,
	input wire logic [7:0] data,
	output logic [7:0] crc_out
);
	// Bitwise MSB-first division; eight shifts per byte.
	always_comb
	begin
		logic [7:0] c;
		c = crc_in ^ data;
		for (int i = 0; i < 8; i++)
			c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0}; // [R21]
		crc_out = c;
	end
endmodule // mtw_crc8

// ===== rtl/mtw_top.sv
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Notes on behaviour
// [R1] Slave direction taken from calling address bit.
// [R2] Ninth-clock acknowledge sampled into nack flag.
// [R3] CRC ready set after each byte; the code sets it only for bytes folded into the CRC.
// [R4] CRC ready cleared by result read.
// [R5] Running CRC over each byte on wire; the code folds only bytes while active or on an address hit.
// [R6] Transmit empty: write clears, shifter load sets.
// [R7] Receive full: capture sets, read clears.
// [R8] Slave loads shifter on read call, ack.
// [R9] Slave nack releases line, holds byte.
// [R10] Master loads after write-address or data ack.
// [R11] Master nack issues stop, no load.
// [R12] Receive register holds address while hit.
// [R13] Read frees register; new load sets flag.
// [R14] Bit rate divider 20 shifted by code.
// [R15] Lost arbitration releases lines until stop.
// [R16] Module off releases bus, clears busy.
// [R17] CRC register readable while on and ready.
// [R18] Software copies CRC into transmit register.
// [R19] Module off restores all flags.
// [R20] Address hit set at match, cleared next.
// [R21] CRC polynomial x8+x2+x+1, zero start.
module mtw_top
	import mtw_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n
);
	// ======================================================
	// Declarations
	// ======================================================
	mtw_mst_t mst_st_q, mst_st_d;
	logic on_q, mst_q, dir_q, noack_q;
	logic [7:0] own_q, baud_q, txd_q;
	logic scl_p_q, sda_p_q, busy_q, lost_q;
	logic [3:0] cnt_q;
	logic addr_ph_q, act_q, xmit_q, ackdrv_q, need_tx_q, stop_req_q;
	logic [7:0] shr_q, sht_q, rxd_q, pbuf_q, crc_run_q, crc_res_q;
	logic rx_nack_flag_q, slave_dir_flag_q, addr_hit_flag_q;
	logic tx_empty_flag_q, rx_full_flag_q, tx_done_flag_q;
	logic rx_new_flag_q, crc_ready_flag_q, rx_pend_q;
	logic bvalid_q, rvalid_q, scl_oe_n_q, sda_oe_n_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [7:0] crc_nx, st_v, ct_v, rmux;
	logic tick, clr, half_q, htick;

	// One-hot register select, shared by both bus directions.
	function automatic logic [6:0] reg_dec(input logic [7:0] a);
		reg_dec = 7'h00;
		case (a)
			ADDR_STATUS: reg_dec = 7'h01;
			ADDR_TXD: reg_dec = 7'h02;
			ADDR_RXD: reg_dec = 7'h04;
			ADDR_CRC: reg_dec = 7'h08;
			ADDR_BAUD: reg_dec = 7'h10;
			ADDR_CTRL: reg_dec = 7'h20;
			ADDR_OWN: reg_dec = 7'h40;
			default: reg_dec = 7'h00;
		endcase
	endfunction

	// ======================================================
	// Bus slave decode
	// ======================================================
	// Address and data are taken together, so neither can run ahead.
	wire wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
	wire [6:0] wdec = reg_dec(s_axi_awaddr);
	wire [6:0] wsel = wdec & {7{wr_fire & s_axi_wstrb[0]}};
	wire ar_fire = s_axi_arvalid & ~rvalid_q;
	wire [6:0] rdec = reg_dec(s_axi_araddr);
	wire [6:0] rsel = rdec & {7{ar_fire}};
	wire [7:0] wd = s_axi_wdata[7:0];
	wire wr_st = wsel[0];
	wire wr_txd = wsel[1];
	wire rd_rxd = rsel[2];
	wire rd_crc = rsel[3];
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign s_axi_arready = ~rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	// ======================================================
	// Wire events and transfer roles
	// ======================================================
	// Pins are taken as synchronous, so one stage of history suffices.
	wire scl_rise = scl_i & ~scl_p_q;
	wire scl_fall = ~scl_i & scl_p_q;
	wire start_ev = scl_i & scl_p_q & sda_p_q & ~sda_i;
	wire stop_ev = scl_i & scl_p_q & ~sda_p_q & sda_i;
	wire at_ack = (cnt_q == BIT_ACK);
	wire pre_bit = (cnt_q == BIT_PRE);
	wire byte_end = scl_fall & (cnt_q == BIT_LAST);
	wire ack_end = scl_fall & at_ack;
	wire mst_run = (mst_st_q != M_IDLE);
	wire tx_now = addr_ph_q ? mst_run : (xmit_q & act_q);
	wire own_match = (shr_q[7:1] == own_q[7:1]) | (shr_q[7:1] == 7'h00);
	wire hit = byte_end & addr_ph_q & ~mst_run & own_match;
	wire rx_cap = byte_end & ((~addr_ph_q & act_q & ~xmit_q) | hit);
	wire ack_give = hit | (rx_cap & ~noack_q);
	wire tx_nak = tx_now & rx_nack_flag_q;
	wire want_tx = ack_end & act_q & (addr_ph_q ?
		(mst_run ? (~dir_q & ~rx_nack_flag_q) : slave_dir_flag_q) :
		(xmit_q & ~rx_nack_flag_q)); // [R8] [R10]
	wire load_tx = need_tx_q & ~tx_empty_flag_q & ~wr_txd;
	wire arb_lost = mst_run & scl_rise & tx_now & ~at_ack & sht_q[7] & ~sda_i;
	wire start_clash = mst_q & ~mst_run & busy_q & ~lost_q;
	wire lost_ev = on_q & (arb_lost | start_clash);
	wire rx_ld = ~rx_full_flag_q & (rx_pend_q | rx_cap);
	wire [7:0] rx_src = rx_pend_q ? pbuf_q : shr_q;
	wire crc_step = byte_end & (act_q | hit); // [R5]
	wire hold = act_q & (need_tx_q | rx_pend_q);
	assign clr = ~aresetn | ~on_q; // [R19]

	// Line drive: the shifter bit, the ninth-clock acknowledge, master framing.
	wire m_sda = (mst_st_q == M_START) | (mst_st_q == M_STOP) |
		(mst_st_q == M_END);
	wire m_scl = (mst_st_q == M_LOW) | (mst_st_q == M_STOP);
	wire sda_low = on_q & (m_sda | ackdrv_q |
		(tx_now & ~at_ack & ~sht_q[7]));
	wire scl_low = on_q & (m_scl | hold);
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;
	assign scl_oe_n = scl_oe_n_q;
	assign sda_oe_n = sda_oe_n_q;

	mtw_baud u_baud (
		.aclk(aclk),
		.aresetn(aresetn),
		.en(on_q),
		.sel(baud_q[2:0]),
		.tick(tick)
	);

	mtw_crc8 u_crc (
		.crc_in(crc_run_q),
		.data(shr_q),
		.crc_out(crc_nx)
	);

	// ======================================================
	// Pin registers, bus busy, lost arbitration
	// ======================================================
	// Turning the module off drops every drive and frees a hung bus.
	always_ff @(posedge aclk)
	begin
		scl_p_q <= scl_i;
		sda_p_q <= sda_i;
		if (clr)
		begin
			busy_q <= 1'b0; // [R16]
			lost_q <= 1'b0;
			scl_oe_n_q <= 1'b1;
			sda_oe_n_q <= 1'b1;
		end
		else
		begin
			scl_oe_n_q <= ~(scl_low & ~lost_ev); // [R15]
			sda_oe_n_q <= ~(sda_low & ~lost_ev); // [R15]
			if (start_ev)
				busy_q <= 1'b1;
			else if (stop_ev)
				busy_q <= 1'b0;
			if (lost_ev)
				lost_q <= 1'b1;
			else if (stop_ev)
				lost_q <= 1'b0; // [R15]
		end
	end

	// ======================================================
	// Master sequencer
	// ======================================================
	// Each wire phase spans two quarter ticks, so one bit takes four.
	assign htick = tick & half_q; // [R14]

	// Phase toggle restarts with the module so the first phase is whole.
	always_ff @(posedge aclk)
	begin
		if (clr)
			half_q <= 1'b0;
		else if (tick)
			half_q <= ~half_q;
	end

	// High phase waits for the wire itself, so a stretching slave is honoured.
	always_comb
	begin
		mst_st_d = mst_st_q;
		unique case (mst_st_q)
			M_IDLE:
				if (htick && mst_q && !busy_q && !lost_q)
					mst_st_d = M_START;
			M_START:
				if (htick)
					mst_st_d = M_LOW;
			M_LOW:
				if (htick && !need_tx_q && !rx_pend_q)
					mst_st_d = stop_req_q ? M_STOP : M_HIGH; // [R11]
			M_HIGH:
				if (htick && scl_i)
					mst_st_d = M_LOW;
			M_STOP:
				if (htick)
					mst_st_d = M_END;
			M_END:
				if (htick)
					mst_st_d = M_IDLE;
			default:
				mst_st_d = M_IDLE;
		endcase
		if (lost_ev)
			mst_st_d = M_IDLE; // [R15]
	end

	always_ff @(posedge aclk)
	begin
		if (clr)
			mst_st_q <= M_IDLE;
		else
			mst_st_q <= mst_st_d;
	end

	// ======================================================
	// Bit and byte engine
	// ======================================================
	always_ff @(posedge aclk)
	begin
		if (clr)
		begin
			cnt_q <= 4'h0;
			addr_ph_q <= 1'b0;
			act_q <= 1'b0;
			xmit_q <= 1'b0;
			shr_q <= DATA_RST;
			sht_q <= DATA_RST;
			ackdrv_q <= 1'b0;
			need_tx_q <= 1'b0;
			stop_req_q <= 1'b0;
		end
		else if (start_ev)
		begin
			cnt_q <= BIT_PRE; // The fall that follows START is no bit.
			addr_ph_q <= 1'b1;
			act_q <= mst_run;
			ackdrv_q <= 1'b0;
			need_tx_q <= 1'b0;
			sht_q <= {own_q[7:1], dir_q};
		end
		else
		begin
			if (scl_rise && !at_ack)
				shr_q <= {shr_q[6:0], sda_i};
			if (scl_fall)
				cnt_q <= at_ack ? 4'h0 : cnt_q + 4'h1;
			if (scl_fall && !at_ack && !pre_bit)
				sht_q <= {sht_q[6:0], 1'b1};
			if (byte_end)
			begin
				ackdrv_q <= ack_give;
				if (addr_ph_q && (mst_run || hit))
					xmit_q <= mst_run ? ~dir_q : shr_q[0];
				if (hit)
					act_q <= 1'b1;
			end
			if (ack_end)
			begin
				ackdrv_q <= 1'b0;
				addr_ph_q <= 1'b0;
				need_tx_q <= want_tx & ~(mst_run & ~mst_q); // [R11]
				if (!mst_run && tx_nak)
					act_q <= 1'b0; // [R9]
				stop_req_q <= mst_run & (tx_nak | ~mst_q); // [R11]
			end
			if (load_tx)
			begin
				sht_q <= txd_q; // [R8] [R10]
				need_tx_q <= 1'b0;
			end
			if (stop_ev || lost_ev)
			begin
				act_q <= 1'b0;
				need_tx_q <= 1'b0;
				ackdrv_q <= 1'b0;
				addr_ph_q <= 1'b0;
			end
			if (mst_st_q == M_IDLE)
				stop_req_q <= 1'b0;
		end
	end

	// ======================================================
	// Status flags, receive data, CRC
	// ======================================================
	// Where hardware sets and software clears in one cycle, the set wins.
	always_ff @(posedge aclk)
	begin
		if (clr)
		begin
			rx_nack_flag_q <= STATUS_RST[ST_NACK]; // [R2]
			slave_dir_flag_q <= STATUS_RST[ST_SDIR];
			addr_hit_flag_q <= STATUS_RST[ST_HIT];
			tx_empty_flag_q <= STATUS_RST[ST_TXE]; // [R6]
			rx_full_flag_q <= STATUS_RST[ST_RXF]; // [R7]
			tx_done_flag_q <= STATUS_RST[ST_TXDONE];
			rx_new_flag_q <= STATUS_RST[ST_RXNEW];
			crc_ready_flag_q <= STATUS_RST[ST_CRCRDY]; // [R4]
			crc_run_q <= CRC_INIT;
			crc_res_q <= CRC_INIT;
			rxd_q <= DATA_RST;
			pbuf_q <= DATA_RST;
			rx_pend_q <= 1'b0;
		end
		else
		begin
			if (scl_rise && at_ack && tx_now)
				rx_nack_flag_q <= sda_i; // [R2]
			if (hit)
			begin
				slave_dir_flag_q <= shr_q[0]; // [R1]
				addr_hit_flag_q <= 1'b1; // [R20]
			end
			else if (rx_cap && !mst_run)
				addr_hit_flag_q <= 1'b0; // [R20]
			if (load_tx)
				tx_empty_flag_q <= 1'b1; // [R6]
			else if (wr_txd)
				tx_empty_flag_q <= 1'b0; // [R6]
			if (load_tx)
				tx_done_flag_q <= 1'b1;
			else if (wr_st && !wd[ST_TXDONE])
				tx_done_flag_q <= 1'b0;
			if (rx_ld)
				rx_new_flag_q <= 1'b1; // [R13]
			else if (wr_st && !wd[ST_RXNEW])
				rx_new_flag_q <= 1'b0;
			if (rx_ld)
				rx_full_flag_q <= 1'b1; // [R7]
			else if (rd_rxd)
				rx_full_flag_q <= 1'b0; // [R7] [R13]
			if (rx_ld)
			begin
				rxd_q <= rx_src; // [R12] [R13]
				rx_pend_q <= 1'b0;
			end
			else if (rx_cap)
			begin
				pbuf_q <= shr_q;
				rx_pend_q <= 1'b1;
			end
			if (start_ev)
				crc_run_q <= CRC_INIT; // [R21]
			else if (crc_step)
			begin
				crc_run_q <= crc_nx; // [R5]
				crc_res_q <= crc_nx; // [R5]
			end
			if (crc_step)
				crc_ready_flag_q <= 1'b1; // [R3]
			else if (rd_crc)
				crc_ready_flag_q <= 1'b0; // [R4]
		end
	end

	// ======================================================
	// Software registers
	// ======================================================
	// Master-run is dropped by hardware on any refused byte it sends, address or data, or on a lost bus.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			on_q <= CTRL_RST[CT_ON];
			mst_q <= CTRL_RST[CT_MST];
			dir_q <= CTRL_RST[CT_DIR];
			noack_q <= CTRL_RST[CT_NOACK];
			own_q <= DATA_RST;
			baud_q <= DATA_RST;
			txd_q <= DATA_RST;
		end
		else
		begin
			if (wsel[5])
			begin
				on_q <= wd[CT_ON]; // [R16]
				mst_q <= wd[CT_MST];
				dir_q <= wd[CT_DIR];
				noack_q <= wd[CT_NOACK];
			end
			if (lost_ev || (ack_end && mst_run && tx_nak))
				mst_q <= 1'b0; // [R11] [R15]
			if (wsel[6])
				own_q <= wd;
			if (wsel[4])
				baud_q <= {5'h00, wd[2:0]};
			if (wr_txd)
				txd_q <= wd;
		end
	end

	// ======================================================
	// Read mux and bus responses
	// ======================================================
	assign st_v[ST_NACK] = rx_nack_flag_q;
	assign st_v[ST_SDIR] = slave_dir_flag_q;
	assign st_v[ST_CRCRDY] = crc_ready_flag_q;
	assign st_v[ST_TXE] = tx_empty_flag_q;
	assign st_v[ST_RXF] = rx_full_flag_q;
	assign st_v[ST_HIT] = addr_hit_flag_q;
	assign st_v[ST_TXDONE] = tx_done_flag_q;
	assign st_v[ST_RXNEW] = rx_new_flag_q;
	assign ct_v = {2'h0, lost_q, busy_q, noack_q, dir_q, mst_q, on_q};
	wire crc_vis = on_q & crc_ready_flag_q;
	assign rmux = ({8{rdec[0]}} & st_v) | ({8{rdec[1]}} & txd_q) |
		({8{rdec[2]}} & rxd_q) | ({8{rdec[3] & crc_vis}} & crc_res_q) |
		({8{rdec[4]}} & baud_q) | ({8{rdec[5]}} & ct_v) |
		({8{rdec[6]}} & own_q); // [R17]

	// Unmapped offsets answer with an error and read as zero.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			if (wr_fire)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= (|wdec) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_q <= 1'b0;
			if (ar_fire)
			begin
				rvalid_q <= 1'b1;
				rresp_q <= (|rdec) ? RESP_OKAY : RESP_SLVERR;
				rdata_q <= {24'h00_0000, rmux};
			end
			else if (s_axi_rready)
				rvalid_q <= 1'b0;
		end
	end
endmodule // mtw_top

// ===== bench/mtw_asserts.sv
`timescale 1ns/10ps
// ==========================================================
// Port-level checks of the register bus and the pins
// ==========================================================
module mtw_asserts
	import mtw_pkg::*;
(
	input logic aclk,
	input logic aresetn,
	input logic [7:0] s_axi_awaddr,
	input logic s_axi_awvalid,
	input logic s_axi_awready,
	input logic [31:0] s_axi_wdata,
	input logic [3:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	input logic s_axi_wready,
	input logic [1:0] s_axi_bresp,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [7:0] s_axi_araddr,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic [31:0] s_axi_rdata,
	input logic [1:0] s_axi_rresp,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic scl_o,
	input logic scl_oe_n,
	input logic sda_o,
	input logic sda_oe_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic on_q;
	logic on_d;
	logic w_go;
	// Shadow of the on bit, so off-state checks need no internal probe.
	assign w_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid;
	assign on_d = (w_go && s_axi_awaddr == ADDR_CTRL && s_axi_wstrb[0])
		? s_axi_wdata[CT_ON] : on_q;
	always_ff @(posedge aclk)
		on_q <= aresetn ? on_d : 1'b0;
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	a_b_answer: assert property (w_go |=> s_axi_bvalid)
		else $error("write response late");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid)
		else $error("read data late");
	a_w_refuse: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_drive_zero: assert property (scl_o == 1'b0 && sda_o == 1'b0)
		else $error("pin drives a high level");
	a_off_pins: assert property (!on_q && !$past(on_q) |->
		sda_oe_n && scl_oe_n)
		else $error("lines held while off");
	a_off_status: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == ADDR_STATUS && !on_q && !$past(on_q)
		|=> s_axi_rdata == {24'h0, STATUS_RST})
		else $error("status not at reset value while off");
	a_off_crc: assert property (s_axi_arvalid && s_axi_arready
		&& s_axi_araddr == ADDR_CRC && !on_q |=> s_axi_rdata == 32'h0)
		else $error("crc readable while off");
	a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready
		&& (s_axi_araddr > ADDR_OWN || s_axi_araddr[1:0] != 2'h0)
		|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
endmodule // mtw_asserts

bind mtw_top mtw_asserts mtw_asserts_i (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
	.sda_o(sda_o), .sda_oe_n(sda_oe_n));

// ===== bench/mtw_peer.sv
`timescale 1ns/10ps
// ==========================================================
// Far-side slave on the two-wire bus
// ==========================================================
module mtw_peer
(
	input logic aclk,
	input logic scl,
	input logic sda,
	input logic nack,
	output logic sda_oe_n,
	output logic [23:0] got,
	output int n_got
);
	logic sp = 1'b1;
	logic dp = 1'b1;
	logic [7:0] sh = 8'h00;
	int cnt = 0;
	initial
	begin
		sda_oe_n = 1'b1;
		got = 24'h0;
		n_got = 0;
	end
	// Lines are sampled once a cycle; a START restarts the bit count.
	// Every byte, address included, is kept and acked unless told not to.
	always @(posedge aclk)
	begin
		sp <= scl;
		dp <= sda;
		if (scl && sp && dp && !sda)
			cnt <= 0;
		else if (scl && !sp)
		begin
			sh <= {sh[6:0], sda};
			cnt <= cnt + 1;
		end
		else if (!scl && sp && cnt == 8)
		begin
			got <= {got[15:0], sh};
			n_got <= n_got + 1;
			sda_oe_n <= nack;
		end
		else if (!scl && sp && cnt == 9)
		begin
			sda_oe_n <= 1'b1;
			cnt <= 0;
		end
	end
endmodule // mtw_peer

// ===== bench/multi_master_two_wire_buffers_bench.sv
`timescale 1ns/10ps
// ==========================================================
// Bench
// ==========================================================
module multi_master_two_wire_buffers_bench
	import mtw_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	logic scl_o;
	logic scl_oe_n;
	logic sda_o;
	logic sda_oe_n;
	logic p_sda_oe_n;
	logic nack = 1'b0;
	logic scl;
	logic sda;
	logic [23:0] got;
	logic sc_q = 1'b1;
	logic [1:0] rsp;
	int n_got;
	int bad_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int nr = 0;
	int t_last = 0;
	int per = 0;
	// Pulled-up wires: low whenever any party enables its driver.
	assign scl = scl_oe_n;
	assign sda = sda_oe_n & p_sda_oe_n;
	mtw_top mtw_top_i (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .scl_i(scl), .scl_o(scl_o),
		.scl_oe_n(scl_oe_n), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n));
	mtw_peer mtw_peer_i (.aclk(aclk), .scl(scl), .sda(sda), .nack(nack),
		.sda_oe_n(p_sda_oe_n), .got(got), .n_got(n_got));
	always #2.5 aclk = ~aclk;
	// Cycle count, hang limit, and the period of the third SCL rise.
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		sc_q <= scl;
		if (scl && !sc_q)
		begin
			nr <= nr + 1;
			t_last <= cyc;
			if (nr == 2)
				per <= cyc - t_last;
		end
		if (cyc == 20000)
		begin
			bad_count++;
			results();
		end
	end
	// ======================================================
	// Bus tasks
	// ======================================================
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", s, e, g);
			bad_count++;
		end
	endtask
	// Address and data are each held until their own ready is seen.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge aclk);
			if (!aw_ok && s_axi_awready === 1'b1)
			begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_ok && s_axi_wready === 1'b1)
			begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		@(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// Polling is bounded so a stuck flag is reported, not waited out.
	task automatic poll(input logic [7:0] a, input int i, input logic v);
		logic [31:0] d;
		int k;
		rd(a, d);
		for (k = 0; k < 300 && d[i] !== v; k++)
			rd(a, d);
		chk("polled bit", v, d[i]);
	endtask
	task automatic wt(input int n);
		int k;
		for (k = 0; k < 5000 && n_got < n; k++)
			@(posedge aclk);
		chk("peer bytes", n, n_got);
	endtask
	function automatic logic [7:0] crc8(input logic [7:0] c,
		input logic [7:0] d);
		c = c ^ d;
		repeat (8)
			c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		return c;
	endfunction
	// ======================================================
	// Scenarios
	// ======================================================
	task automatic t_reset;
		logic [31:0] d;
		rd(ADDR_STATUS, d);
		chk("status", 32'h09, d);
		rd(ADDR_CRC, d);
		chk("crc off", 32'h0, d);
		rd(8'h1C, d);
		chk("unmapped read", RESP_SLVERR, rsp);
		wr(8'h20, 32'h0);
		chk("unmapped write", RESP_SLVERR, rsp);
		$display("done reset");
	endtask
	task automatic t_master;
		logic [31:0] d;
		logic [7:0] c;
		c = crc8(crc8(8'h00, 8'hA4), 8'h5A);
		wr(ADDR_BAUD, 32'h1);
		rd(ADDR_BAUD, d);
		chk("baud", 32'h1, d);
		wr(ADDR_OWN, 32'hA4);
		wr(ADDR_CTRL, 32'h1);
		wr(ADDR_TXD, 32'h5A);
		rd(ADDR_STATUS, d);
		chk("tx_empty", 32'h0, d[ST_TXE]);
		wr(ADDR_CTRL, 32'h3);
		poll(ADDR_STATUS, ST_TXE, 1'b1);
		wt(2);
		poll(ADDR_STATUS, ST_CRCRDY, 1'b1);
		rd(ADDR_STATUS, d);
		chk("rx_nack", 32'h0, d[ST_NACK]);
		rd(ADDR_CRC, d);
		chk("crc", c, d);
		rd(ADDR_STATUS, d);
		chk("crc_ready", 32'h0, d[ST_CRCRDY]);
		chk("bit period", 40, per);
		wr(ADDR_TXD, c);
		poll(ADDR_STATUS, ST_TXE, 1'b1);
		wr(ADDR_CTRL, 32'h1);
		wt(3);
		poll(ADDR_CTRL, CT_BUSY, 1'b0);
		chk("bytes", {8'hA4, 8'h5A, c}, got);
		$display("done master transmit");
	endtask
	task automatic t_nack;
		logic [31:0] d;
		nack <= 1'b1;
		wr(ADDR_TXD, 32'h33);
		wr(ADDR_CTRL, 32'h3);
		wt(4);
		poll(ADDR_CTRL, CT_BUSY, 1'b0);
		rd(ADDR_STATUS, d);
		chk("rx_nack", 32'h1, d[ST_NACK]);
		chk("tx_empty", 32'h0, d[ST_TXE]);
		rd(ADDR_CTRL, d);
		chk("master bit", 32'h0, d[CT_MST]);
		chk("lines", 2'b11, {scl, sda});
		chk("address", 8'hA4, got[7:0]);
		wr(ADDR_CTRL, 32'h0);
		rd(ADDR_STATUS, d);
		chk("status off", 32'h09, d);
		rd(ADDR_BAUD, d);
		chk("baud kept", 32'h1, d);
		nack <= 1'b0;
		$display("done master nack");
	endtask
	// Main sequence.
	initial
	begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_master();
		t_nack();
		results();
	end
endmodule // multi_master_two_wire_buffers_bench
